/* rps_host.sv */
// host bus master model driving port zero of the management slave
`timescale 1ns/1ps
module rps_host #(
  parameter logic [6:0] ADDR = 7'h58
) (
  input  wire logic clk,   // bench clock
  input  wire logic scl_w, // resolved clock line
  input  wire logic sda_w, // resolved data line
  output logic      scl,   // high releases clock
  output logic      sda    // high releases data
);
  logic [7:0] crc;
  int         timeouts;
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    timeouts = 0;
  end
  function automatic logic [7:0] step(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++)
      x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction : step
  task automatic q();
    repeat (4) @(posedge clk);
  endtask : q
  // do not clock on while the slave holds the line low, giving up after 1000 cycles
  task automatic hi();
    int n;
    scl <= 1'b1;
    n = 0;
    @(posedge clk);
    while (scl_w !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000)
      timeouts++;
    q();
  endtask : hi
  task automatic bit_io(input logic b, output logic r);
    sda <= b;
    q();
    hi();
    r = sda_w;
    q();
    scl <= 1'b0;
    q();
  endtask : bit_io
  task automatic start();
    sda <= 1'b1;
    q();
    hi();
    sda <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask : start
  task automatic stop();
    sda <= 1'b0;
    q();
    hi();
    sda <= 1'b1;
    q();
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] r, output logic a);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(m, a);
  endtask : xfer
  task automatic send(input logic [7:0] d, inout int nak);
    logic [7:0] r;
    logic       a;
    xfer(d, 1'b1, r, a);
    if (a !== 1'b0)
      nak++;
    crc = step(crc, d);
  endtask : send
  // the host appends the check byte unless told to omit it
  task automatic write(input logic [7:0] cmd, input int n,
                       input logic [7:0] dat, input logic pec,
                       output int nak);
    logic [7:0] p;
    nak = 0;
    start();
    crc = 8'h00;
    send({ADDR, 1'b0}, nak);
    send(cmd, nak);
    if (n > 0)
      send(dat, nak);
    p = crc;
    if (pec)
      send(p, nak);
    stop();
  endtask : write
  task automatic read(input logic [7:0] cmd, output logic [7:0] dat,
                      output logic ok);
    logic [7:0] p;
    logic       a;
    int         nak;
    nak = 0;
    start();
    crc = 8'h00;
    send({ADDR, 1'b0}, nak);
    send(cmd, nak);
    start();
    send({ADDR, 1'b1}, nak);
    xfer(8'hFF, 1'b0, dat, a);
    crc = step(crc, dat);
    xfer(8'hFF, 1'b1, p, a);
    ok = (p === crc) && (nak == 0);
    stop();
  endtask : read
endmodule : rps_host

/* rps_pkg.sv */
// types shared by the rectifier management slave
package rps_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_STRETCH, ST_TX, ST_TXACK, ST_IGNORE
  } rps_state_t;

  typedef struct packed {
    logic output_on;
    logic output_warn;
    logic overload;
    logic overtemp;
    logic fan_fail;
    logic ov_shutdown;
    logic internal_fault;
    logic vin_fault;
    logic vout_fault;
    logic iout_oc;
    logic cap_3000;
  } rps_cond_t;

  typedef struct packed {
    logic off;
    logic internal;
    logic fan;
    logic temp;
    logic iout;
    logic vout;
    logic vin;
    logic pec_err;
    logic data_oor;
    logic cml;
  } rps_status_t;
endpackage : rps_pkg

/* rps_regs.svh */
// register offsets, field positions, command codes and timing figures
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH
`define RPS_CLK_KHZ          100000
`define RPS_MS2CYC(ms)       ((ms) * `RPS_CLK_KHZ)
`define RPS_PG_HALF_MS       1
`define RPS_STRETCH_MAX_MS   25
`define RPS_LOCKUP_MS        35
`define RPS_REINIT_MS        5000
`define RPS_OTW_MS           10000
`define RPS_SLAVE_ADDR       7'h58
`define RPS_CMD_OPERATION    8'h01
`define RPS_CMD_CLEAR        8'h03
`define RPS_CMD_STATUS_BYTE  8'h78
`define RPS_LEN_CLEAR        3'h3
`define RPS_LEN_OPERATION    3'h4
`define RPS_OP_RSVD_MASK     8'h3F
`define RPS_OP_RESET         8'h80
`define RPS_CRC_POLY         8'h07
`define RPS_TX_FILL          8'hFF
`define RPS_LAST_BIT         3'h7
`define RPS_ADR_CTRL         8'h00
`define RPS_ADR_STRETCH      8'h04
`define RPS_ADR_STATUS       8'h08
`define RPS_ADR_BUSINFO      8'h0C
`define RPS_ADR_OPER         8'h10
`define RPS_CTRL_FAST_BIT    0
`define RPS_CTRL_OWNER_BIT   1
`endif

/* rps_top.sv */
// rectifier management bus slave with status pins and attention line
`timescale 1ns/1ps
`include "rps_regs.svh"
module rps_top
  import rps_pkg::*;
#(
  parameter int         PG_HALF_CYC     = `RPS_MS2CYC(`RPS_PG_HALF_MS),
  parameter int         STRETCH_MAX_CYC = `RPS_MS2CYC(`RPS_STRETCH_MAX_MS),
  parameter int         LOCKUP_CYC      = `RPS_MS2CYC(`RPS_LOCKUP_MS),
  parameter int         REINIT_CYC      = `RPS_MS2CYC(`RPS_REINIT_MS),
  parameter int         OTW_CYC         = `RPS_MS2CYC(`RPS_OTW_MS),
  parameter logic [6:0] SLAVE_ADDR      = `RPS_SLAVE_ADDR
) (
  input  wire logic        clk,                   // 100 MHz
  input  wire logic        sys_rst,               // sync, active high
  input  wire logic        wb_cyc_i,              // wishbone cycle
  input  wire logic        wb_stb_i,              // wishbone strobe
  input  wire logic        wb_we_i,               // write enable
  input  wire logic [7:0]  wb_adr_i,              // byte address
  input  wire logic [31:0] wb_dat_i,              // write data
  input  wire logic [3:0]  wb_sel_i,              // byte lanes
  output logic      [31:0] wb_dat_o,              // read data
  output logic             wb_ack_o,              // acknowledge
  input  wire logic        scl_a_i,               // port zero clock in
  input  wire logic        sda_a_i,               // port zero data in
  input  wire logic        scl_b_i,               // port one clock in
  input  wire logic        sda_b_i,               // port one data in
  output logic             scl_a_o,               // always low
  output logic             scl_a_oe_n,            // low pulls clock
  output logic             sda_a_o,               // always low
  output logic             sda_a_oe_n,            // low pulls data
  output logic             scl_b_o,               // always low
  output logic             scl_b_oe_n,            // low pulls clock
  output logic             sda_b_o,               // always low
  output logic             sda_b_oe_n,            // low pulls data
  input  wire rps_cond_t   cond_i,                // power stage state
  output logic             output_good_warning_n, // output good
  output logic             replace_fault_n,       // replace unit
  output logic             overtemp_warning_n,    // overtemp warning
  output logic             power_capability_flag, // 3000w capable
  output logic             thermal_shutdown,      // stop power stage
  output logic             attention_line_n,      // alert to port zero
  output logic             attention_line_b_n     // alert to port one
);

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ((r << 1) ^ `RPS_CRC_POLY) : (r << 1);
    return r;
  endfunction : crc8

  // pin synchronisers: meta stage is read only by the sync stage
  logic [3:0] pin_raw, pin_meta_q, pin_sync_q, pin_prev_q;
  assign pin_raw = {sda_b_i, scl_b_i, sda_a_i, scl_a_i};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          pin_meta_q[g] <= 1'b1;
          pin_sync_q[g] <= 1'b1;
          pin_prev_q[g] <= 1'b1;
        end
        else
        begin
          pin_meta_q[g] <= pin_raw[g];
          pin_sync_q[g] <= pin_meta_q[g];
          pin_prev_q[g] <= pin_sync_q[g];
        end
      end
    end
  endgenerate

  logic        fast_q, owner_q, owner_p_q;
  logic [23:0] stretch_len_q;
  logic [7:0]  oper_q;
  // only the owning port is watched; the other stays released
  wire scl   = owner_q ? pin_sync_q[2] : pin_sync_q[0];
  wire sda   = owner_q ? pin_sync_q[3] : pin_sync_q[1];
  wire scl_p = owner_q ? pin_prev_q[2] : pin_prev_q[0];
  wire sda_p = owner_q ? pin_prev_q[3] : pin_prev_q[1];
  wire start_ev = scl & scl_p & sda_p & ~sda;
  wire stop_ev  = scl & scl_p & ~sda_p & sda;
  wire scl_rise = scl & ~scl_p;
  wire scl_fall = ~scl & scl_p;

  // lock-up and inactivity watchdogs
  logic [31:0] lock_cnt_q, idle_cnt_q;
  wire lock_abort = (lock_cnt_q == 32'(LOCKUP_CYC));
  wire reinit     = (idle_cnt_q == 32'(REINIT_CYC - 1));
  wire abort_ev   = lock_abort | reinit | (owner_q != owner_p_q);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lock_cnt_q <= '0;
    else if (scl & sda)
      lock_cnt_q <= '0;
    else if (lock_cnt_q <= 32'(LOCKUP_CYC))
      lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || reinit || scl != scl_p || sda != sda_p)
      idle_cnt_q <= '0;
    else
      idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
  end

  // byte engine
  rps_state_t  state_q, ret_q;
  logic [2:0]  bitcnt_q, byte_idx_q;
  logic [7:0]  shreg_q, txsh_q, cmd_q, data_q, last_q, crc_q, crc_prev_q;
  logic [31:0] str_cnt_q;
  logic        is_read_q, in_txn_q, tx_idx_q, tx_load, ack_q;
  rps_status_t status_q, status_d, status_ev;
  logic        cmd_known, sda_drv_d;
  logic [7:0]  tx_data;
  wire  [7:0]  rx_byte   = {shreg_q[6:0], sda};
  wire         byte_done = (state_q == ST_RX) && scl_rise
                           && (bitcnt_q == `RPS_LAST_BIT);
  wire  [31:0] str_lim   = ({8'h00, stretch_len_q} > 32'(STRETCH_MAX_CYC))
                           ? 32'(STRETCH_MAX_CYC) : {8'h00, stretch_len_q};
  wire         str_done  = (str_cnt_q + 32'h0000_0001 >= str_lim);

  always_comb
  begin
    cmd_known = 1'b1;
    tx_data   = 8'h00;
    case (cmd_q)
      `RPS_CMD_OPERATION:   tx_data = oper_q;
      `RPS_CMD_STATUS_BYTE: tx_data = status_q[7:0];
      default:              cmd_known = 1'b0; // zero data
    endcase
  end
  assign tx_load = (state_q == ST_ACK) && scl_fall && ack_q && is_read_q
                   && (byte_idx_q == 3'h1);

  always_ff @(posedge clk)
  begin
    if (sys_rst || abort_ev)
    begin
      state_q    <= ST_IDLE; // release everything
      in_txn_q   <= 1'b0;
      bitcnt_q   <= '0;
      byte_idx_q <= '0;
      is_read_q  <= 1'b0;
      crc_q      <= '0;
      str_cnt_q  <= '0;
      ack_q      <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_q  <= ST_IDLE;
      in_txn_q <= 1'b0;
    end
    else if (start_ev)
    begin
      state_q    <= ST_RX;
      bitcnt_q   <= '0;
      byte_idx_q <= '0;
      if (!in_txn_q)
        crc_q <= '0; // a repeated start keeps the running check
    end
    else
    begin
      case (state_q)
        ST_RX:
          if (scl_rise)
          begin
            shreg_q  <= rx_byte;
            bitcnt_q <= bitcnt_q + 3'h1;
            if (byte_done && byte_idx_q == 3'h0
                && rx_byte[7:1] != SLAVE_ADDR)
              state_q <= ST_IGNORE;
            else if (byte_done)
            begin
              crc_prev_q <= crc_q;
              crc_q      <= crc8(crc_q, rx_byte);
              last_q     <= rx_byte;
              if (byte_idx_q != 3'h7)
                byte_idx_q <= byte_idx_q + 3'h1;
              if (byte_idx_q == 3'h0)
              begin
                is_read_q <= rx_byte[0];
                in_txn_q  <= 1'b1;
              end
              if (byte_idx_q == 3'h1)
                cmd_q <= rx_byte;
              if (byte_idx_q == 3'h2)
                data_q <= rx_byte;
              state_q <= ST_ACK;
              ack_q   <= 1'b0;
            end
          end
        ST_ACK:
          // first fall opens the ninth clock, the second one closes it
          if (scl_fall && !ack_q)
            ack_q <= 1'b1;
          else if (scl_fall)
          begin
            ack_q     <= 1'b0;
            ret_q     <= tx_load ? ST_TX : ST_RX;
            state_q   <= (stretch_len_q != '0) ? ST_STRETCH
                         : (tx_load ? ST_TX : ST_RX);
            str_cnt_q <= '0;
            if (tx_load)
            begin
              txsh_q   <= tx_data;
              crc_q    <= crc8(crc_q, tx_data);
              tx_idx_q <= 1'b0;
            end
          end
        ST_STRETCH:
          if (str_done)
            state_q <= ret_q;
          else
            str_cnt_q <= str_cnt_q + 32'h0000_0001;
        ST_TX:
          if (scl_fall)
          begin
            txsh_q   <= {txsh_q[6:0], 1'b0};
            bitcnt_q <= bitcnt_q + 3'h1;
            if (bitcnt_q == `RPS_LAST_BIT)
              state_q <= ST_TXACK;
          end
        ST_TXACK:
          if (scl_rise && sda)
            state_q <= ST_IGNORE; // host ends the read with nack
          else if (scl_fall)
          begin
            state_q  <= ST_TX;
            tx_idx_q <= 1'b1;
            txsh_q   <= tx_idx_q ? `RPS_TX_FILL : crc_q;
          end
        default: ;
      endcase
    end
  end

  // the device only ever pulls lines low, never generates clocks
  always_comb
  begin
    case (state_q)
      ST_ACK:     sda_drv_d = ack_q;
      ST_TX:      sda_drv_d = ~txsh_q[7];
      ST_STRETCH: sda_drv_d = (ret_q == ST_TX) & ~txsh_q[7];
      default:    sda_drv_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      {scl_a_oe_n, sda_a_oe_n, scl_b_oe_n, sda_b_oe_n} <= 4'hF;
      {scl_a_o, sda_a_o, scl_b_o, sda_b_o} <= 4'h0;
    end
    else
    begin
      scl_a_oe_n <= ~((state_q == ST_STRETCH) & ~owner_q);
      sda_a_oe_n <= ~(sda_drv_d & ~owner_q);
      scl_b_oe_n <= ~((state_q == ST_STRETCH) & owner_q);
      sda_b_oe_n <= ~(sda_drv_d & owner_q);
    end
  end

  // write decode at stop: last byte must be the check byte
  wire       wr_end  = stop_ev && in_txn_q && !is_read_q && !abort_ev;
  wire       pec_ok  = (crc_prev_q == last_q);
  wire [2:0] exp_len = (cmd_q == `RPS_CMD_CLEAR) ? `RPS_LEN_CLEAR
                     : (cmd_q == `RPS_CMD_OPERATION) ? `RPS_LEN_OPERATION
                     : 3'h0;
  wire       len_ok  = (byte_idx_q == exp_len) && (exp_len != 3'h0);
  wire       no_pec  = (byte_idx_q == exp_len - 3'h1);
  wire       exec    = wr_end && len_ok && pec_ok;
  wire       clear_ev = exec && (cmd_q == `RPS_CMD_CLEAR);
  wire       oor     = |(data_q & `RPS_OP_RSVD_MASK);
  wire       ev_oor  = exec && (cmd_q == `RPS_CMD_OPERATION) && oor;
  wire       ev_pec  = wr_end && byte_idx_q >= 3'h3 && !pec_ok && !no_pec;
  wire       ev_cml  = (wr_end && byte_idx_q >= 3'h3 && pec_ok && !len_ok)
                       || (tx_load && !cmd_known);

  // status and attention
  rps_cond_t   cond_p_q;
  logic        att_q, shutdown_q;
  always_comb
  begin
    status_ev          = '0;
    status_ev.cml      = ev_cml;
    status_ev.data_oor = ev_oor;
    status_ev.pec_err  = ev_pec;
    status_d           = status_ev;
    status_d.vin       = cond_i.vin_fault;
    status_d.vout      = cond_i.vout_fault;
    status_d.iout      = cond_i.iout_oc;
    status_d.temp      = cond_i.overtemp;
    status_d.fan       = cond_i.fan_fail;
    status_d.internal  = cond_i.internal_fault | cond_i.ov_shutdown;
    status_d.off       = ~cond_i.output_on;
    // persisting faults come back one cycle after a clear
    status_d = clear_ev ? status_ev : (status_q | status_d);
  end
  wire att_set = |(status_d & ~status_q) || (cond_i != cond_p_q)
                 || ev_cml || ev_oor || ev_pec;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_q <= '0;
      cond_p_q <= '0;
      att_q    <= 1'b1;
    end
    else
    begin
      status_q <= status_d;
      cond_p_q <= cond_i;
      if (att_set)
        att_q <= 1'b1; // a new change wins over a clear
      else if (clear_ev)
        att_q <= 1'b0;
    end
  end

  // discrete status pins
  logic [31:0] pg_cnt_q, ot_cnt_q;
  logic        pg_tog_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst || pg_cnt_q == 32'(PG_HALF_CYC - 1))
      pg_cnt_q <= '0;
    else
      pg_cnt_q <= pg_cnt_q + 32'h0000_0001;
    if (sys_rst)
      pg_tog_q <= 1'b0;
    else if (pg_cnt_q == 32'(PG_HALF_CYC - 1))
      pg_tog_q <= ~pg_tog_q;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || !cond_i.overtemp)
    begin
      ot_cnt_q   <= '0;
      shutdown_q <= 1'b0; // restart once temperature recovers
    end
    else if (ot_cnt_q < 32'(OTW_CYC))
      ot_cnt_q <= ot_cnt_q + 32'h0000_0001;
    else
      shutdown_q <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      output_good_warning_n <= 1'b0;
      replace_fault_n       <= 1'b1;
      overtemp_warning_n    <= 1'b1;
      power_capability_flag <= 1'b0;
      thermal_shutdown      <= 1'b0;
      attention_line_n      <= 1'b0;
      attention_line_b_n    <= 1'b0;
    end
    else
    begin
      output_good_warning_n <= cond_i.overload ? pg_tog_q
                  : (cond_i.output_on & ~cond_i.output_warn);
      replace_fault_n <= ~(cond_i.fan_fail | shutdown_q
                  | cond_i.ov_shutdown | cond_i.internal_fault);
      overtemp_warning_n    <= ~cond_i.overtemp;
      power_capability_flag <= cond_i.cap_3000;
      thermal_shutdown      <= shutdown_q;
      attention_line_n      <= ~att_q;
      attention_line_b_n    <= ~att_q;
    end
  end

  // wishbone classic slave, one wait state
  wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land at the edge where the master sees ack
  wire wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= '0;
      fast_q        <= 1'b0;
      owner_q       <= 1'b0;
      owner_p_q     <= 1'b0;
      stretch_len_q <= '0;
      oper_q        <= `RPS_OP_RESET;
    end
    else
    begin
      wb_ack_o  <= wb_hit;
      owner_p_q <= owner_q;
      if (ev_oor == 1'b0 && exec && cmd_q == `RPS_CMD_OPERATION)
        oper_q <= data_q;
      if (wb_wr && wb_adr_i == `RPS_ADR_CTRL && wb_sel_i[0])
      begin
        fast_q  <= wb_dat_i[`RPS_CTRL_FAST_BIT];
        owner_q <= wb_dat_i[`RPS_CTRL_OWNER_BIT];
      end
      if (wb_wr && wb_adr_i == `RPS_ADR_STRETCH)
        for (int i = 0; i < 3; i++)
          if (wb_sel_i[i])
            stretch_len_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
      if (wb_hit && !wb_we_i)
        case (wb_adr_i)
          `RPS_ADR_CTRL:    wb_dat_o <= {30'h0000_0000, owner_q, fast_q};
          `RPS_ADR_STRETCH: wb_dat_o <= {8'h00, stretch_len_q};
          `RPS_ADR_STATUS:  wb_dat_o <= {22'h00_0000, status_q};
          `RPS_ADR_BUSINFO: wb_dat_o <= {24'h00_0000, att_q, state_q,
                                         pin_sync_q};
          `RPS_ADR_OPER:    wb_dat_o <= {24'h00_0000, oper_q};
          default:          wb_dat_o <= 32'h0000_0000;
        endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_pg_overload;
    cond_i.overload && $past(cond_i.overload)
      && $past(pg_tog_q) != pg_tog_q
      |=> $changed(output_good_warning_n);
  endproperty
  a_pg_overload: assert property (p_pg_overload)
    else $error("output good does not follow overload toggle");

  property p_fault;
    cond_i.fan_fail |=> !replace_fault_n;
  endproperty
  a_fault: assert property (p_fault)
    else $error("replace fault not driven on fan failure");

  property p_ot_shutdown;
    !cond_i.overtemp ##1 cond_i.overtemp [*2] |-> !shutdown_q;
  endproperty
  a_ot_shutdown: assert property (p_ot_shutdown)
    else $error("shutdown without warning period");

  property p_unsup_read;
    tx_load && !cmd_known |=> txsh_q == 8'h00 && status_q.cml;
  endproperty
  a_unsup_read: assert property (p_unsup_read)
    else $error("unsupported read not zero or not flagged");

  property p_stretch_max;
    state_q == ST_STRETCH |-> str_cnt_q < 32'(STRETCH_MAX_CYC);
  endproperty
  a_stretch_max: assert property (p_stretch_max)
    else $error("clock stretch exceeds limit");

  property p_lockup;
    lock_abort |=> state_q == ST_IDLE ##1 scl_a_oe_n && sda_a_oe_n
      && scl_b_oe_n && sda_b_oe_n;
  endproperty
  a_lockup: assert property (p_lockup)
    else $error("bus not released after lock-up");

  property p_bad_pec;
    wr_end && !pec_ok |-> !exec;
  endproperty
  a_bad_pec: assert property (p_bad_pec)
    else $error("command executed with bad check byte");

  property p_att_latch;
    att_q && !clear_ev |=> att_q ##1 !attention_line_n;
  endproperty
  a_att_latch: assert property (p_att_latch)
    else $error("attention released without clear");

  property p_att_set;
    att_set |=> att_q;
  endproperty
  a_att_set: assert property (p_att_set)
    else $error("state change did not raise attention");

endmodule : rps_top

/* rps_top_bench.sv */
// self-checking bench for the rectifier management slave
`timescale 1ns/1ps
module rps_top_bench
  import rps_pkg::*;
;
  localparam int PGH = 50;
  localparam int STR = 200;
  localparam int OTW = 100;
  localparam int LCK = 800;
  logic        clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack_o;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_dat_o, r;
  rps_cond_t   cond;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, h_scl, h_sda;
  logic        pg, rf, otw, cap, tsd, att, att_b, ok, a, hold_n;
  logic [7:0]  d;
  wire logic   scl_w = h_scl & (scl_oe_n | scl_o);
  wire logic   sda_w = h_sda & hold_n & (sda_oe_n | sda_o);
  int          n_errors, total_checks, nak, low_run, max_low;

  rps_top #(.PG_HALF_CYC(PGH), .STRETCH_MAX_CYC(STR), .LOCKUP_CYC(LCK),
    .REINIT_CYC(5000), .OTW_CYC(OTW)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_sel_i(4'hF), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .scl_a_i(scl_w), .sda_a_i(sda_w), .scl_b_i(1'b1), .sda_b_i(1'b1),
    .scl_a_o(scl_o), .scl_a_oe_n(scl_oe_n), .sda_a_o(sda_o),
    .sda_a_oe_n(sda_oe_n), .scl_b_o(), .scl_b_oe_n(), .sda_b_o(),
    .sda_b_oe_n(), .cond_i(cond), .output_good_warning_n(pg),
    .replace_fault_n(rf), .overtemp_warning_n(otw),
    .power_capability_flag(cap), .thermal_shutdown(tsd),
    .attention_line_n(att), .attention_line_b_n(att_b));
  rps_host i_host (.clk(clk), .scl_w(scl_w), .sda_w(sda_w),
    .scl(h_scl), .sda(h_sda));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // longest run of the device holding the clock line low
  always @(posedge clk)
  begin
    low_run = (scl_oe_n === 1'b0) ? low_run + 1 : 0;
    if (low_run > max_low)
      max_low = low_run;
  end
  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat);
    int n;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      print_verdict();
    end
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic clr();
    i_host.write(8'h03, 0, 8'h00, 1'b1, nak);
    chk(nak, 0);
    repeat (2) @(posedge clk);
    chk(att, 1'b1);
  endtask : clr
  task automatic t_power_up();
    chk(att, 1'b0);
    chk(att_b, 1'b0);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    clr();
    chk(att_b, 1'b1);
    wb(1'b0, 8'h08, 32'h0000_0000);
    chk(r, 32'h0000_0000);
  endtask : t_power_up
  task automatic t_pins();
    chk(pg, 1'b1);
    chk(cap, 1'b1);
    cond.fan_fail <= 1'b1;
    repeat (3) @(posedge clk);
    chk(rf, 1'b0);
    chk(att, 1'b0);
    cond.fan_fail <= 1'b0;
    cond.overtemp <= 1'b1;
    repeat (3) @(posedge clk);
    chk({otw, tsd, rf}, 3'b001);
    repeat (OTW) @(posedge clk);
    chk({tsd, rf}, 2'b10);
    cond.overtemp <= 1'b0;
    cond.cap_3000 <= 1'b0;
    repeat (3) @(posedge clk);
    chk({otw, tsd, rf, cap}, 4'b1010);
    cond.cap_3000 <= 1'b1;
    cond.overload <= 1'b1;
    repeat (3) @(posedge clk);
    a = pg;
    repeat (PGH) @(posedge clk);
    chk(pg, !a);
    cond.overload <= 1'b0;
    cond.output_warn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pg, 1'b0);
    cond.output_warn <= 1'b0;
    repeat (3) @(posedge clk);
    clr();
  endtask : t_pins
  task automatic t_cmds();
    i_host.write(8'h55, 0, 8'h00, 1'b1, nak);
    repeat (20) @(posedge clk); // settle before reading status
    wb(1'b0, 8'h08, 32'h0000_0000);
    chk({r[0], att}, 2'b10);
    clr();
    i_host.read(8'h55, d, ok);
    chk({d, ok}, 9'h001);
    clr();
    i_host.write(8'h01, 1, 8'h01, 1'b1, nak);
    wb(1'b0, 8'h08, 32'h0000_0000);
    chk({r[1], att}, 2'b10);
    i_host.write(8'h03, 0, 8'h00, 1'b0, nak);
    repeat (4) @(posedge clk);
    chk(att, 1'b0);
    clr();
  endtask : t_cmds
  // a data line held low must abort and release the bus
  task automatic t_lockup();
    hold_n <= 1'b0;
    repeat (LCK + 20) @(posedge clk);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    chk(r[6:4], ST_IDLE);
    chk({scl_oe_n, sda_oe_n}, 2'b11);
    hold_n <= 1'b1;
    repeat (4) @(posedge clk);
    clr();
  endtask : t_lockup
  task automatic t_stretch();
    wb(1'b1, 8'h04, 32'h0000_03E8);
    max_low = 0;
    clr();
    chk(max_low > 0 && max_low <= STR + 2, 1'b1);
    chk(i_host.timeouts, 0);
  endtask : t_stretch
  initial
  begin
    sys_rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat = 32'h0000_0000;
    cond = '0;
    hold_n = 1'b1;
    cond.output_on = 1'b1;
    cond.cap_3000 = 1'b1;
    n_errors = 0;
    total_checks = 0;
    low_run = 0;
    max_low = 0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_power_up();
    t_pins();
    t_cmds();
    t_lockup();
    t_stretch();
    print_verdict();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule : rps_top_bench
